// ### core/rxc_pkg.sv
package rxc_pkg;

  // Register locations in bank 1
  localparam logic [7:0] ADDR_CTL_A = 8'h4A;
  localparam logic [7:0] ADDR_CTL_B = 8'h4B;
  localparam logic [7:0] ADDR_STK_LO = 8'h4E;
  localparam logic [7:0] ADDR_STK_HI = 8'h4F;
  localparam logic [7:0] ADDR_BURST_DATA = 8'h53;

  // Address recovery stack
  localparam int STACK_DEPTH = 4;
  localparam int STK_IDX_LO = 2;
  localparam int STK_IDX_HI = 3;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int UPDATE_LEAD_NS = 122000;
  localparam int UPDATE_LEAD_CYC =
    (UPDATE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Synchronised pin group
  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic kick_n;
    logic ram_clear_in_n;
    logic vcc_ok;
    logic batt_ok;
    logic [7:0] ad;
  } rxc_pins_type;

  // Active-low strobes high, ALE low, power and battery absent, bus zero
  localparam logic [15:0] PINS_IDLE = 16'h7C00;

  typedef struct packed {
    logic batt_ok;
    logic upd;
    logic burst;
    logic resv;
    logic power_off_ctl;
    logic rf;
    logic wf;
    logic kf;
  } rxc_ctl_a_type;

  typedef struct packed {
    logic aux_en;
    logic osc_en;
    logic xtal;
    logic ram_clear_en;
    logic power_fail_keep;
    logic ram_clear_int_en;
    logic wake_int_en;
    logic kick_en;
  } rxc_ctl_b_type;

  localparam logic [7:0] CTL_A_RST = 8'h08;
  localparam logic [7:0] CTL_B_RST = 8'h40;

  typedef enum logic [2:0] {
    UPD_IDLE = 3'h1,
    UPD_LEAD = 3'h2,
    UPD_BUSY = 3'h4
  } rxc_upd_type;

endpackage

// ### core/rxc_ext_ctl.sv
`timescale 1ns/1ns
module rxc_ext_ctl #(
  parameter int UPDATE_LEAD_CYC = rxc_pkg::UPDATE_LEAD_CYC
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Multiplexed host bus
  input wire logic ALE_I,
  input wire logic RD_N_I,
  input wire logic WR_N_I,
  input wire logic CS_N_I,
  input wire logic [7:0] AD_I,
  output logic [7:0] AD_O,
  output logic AD_OE_O,
  input wire logic BANK_SELECT_I,
  // Device pins
  input wire logic KICKSTART_N_I,
  input wire logic RAM_CLEAR_N_I,
  input wire logic VCC_OK_I,
  input wire logic AUX_BATTERY_OK_I,
  // Clock and calendar core
  input wire logic WAKE_EVENT_I,
  input wire logic UPDATE_REQ_I,
  input wire logic UPDATE_DONE_I,
  output logic UPDATE_GO_O,
  output logic BURST_INC_O,
  output logic RAM_CLEAR_O,
  // Open-drain outputs
  output logic PWR_N_O,
  output logic PWR_OE_O,
  output logic IRQ_N_O,
  output logic IRQ_OE_O,
  // Static controls
  output logic SQW_EN_O,
  output logic XTAL_LOAD_SEL_O,
  output logic AUX_SUPPLY_EN_O
);

  localparam int CW = $clog2(UPDATE_LEAD_CYC + 1);
  localparam logic [CW-1:0] LEAD_LAST = CW'(UPDATE_LEAD_CYC - 1);

  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Pin synchroniser: a change counts once stages two and three agree
  rxc_pkg::rxc_pins_type raw;
  rxc_pkg::rxc_pins_type s1_q, s2_q, s3_q, pin_q, pin_d;
  assign raw = '{ale: ALE_I, rd_n: RD_N_I, wr_n: WR_N_I, cs_n: CS_N_I,
                 kick_n: KICKSTART_N_I, ram_clear_in_n: RAM_CLEAR_N_I,
                 vcc_ok: VCC_OK_I, batt_ok: AUX_BATTERY_OK_I, ad: AD_I};

  always_comb begin
    pin_d = (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= rxc_pkg::PINS_IDLE;
      s2_q <= rxc_pkg::PINS_IDLE;
      s3_q <= rxc_pkg::PINS_IDLE;
      pin_q <= rxc_pkg::PINS_IDLE;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end

  logic ale_fall, rd_rise, wr_rise, kick_fall, ram_clear_in_fall;
  logic vcc_rise, vcc_fall;
  assign ale_fall = pin_q.ale & ~pin_d.ale;
  assign rd_rise = ~pin_q.rd_n & pin_d.rd_n;
  assign wr_rise = ~pin_q.wr_n & pin_d.wr_n;
  assign kick_fall = pin_q.kick_n & ~pin_d.kick_n;
  assign ram_clear_in_fall = pin_q.ram_clear_in_n & ~pin_d.ram_clear_in_n;
  assign vcc_rise = ~pin_q.vcc_ok & pin_d.vcc_ok;
  assign vcc_fall = pin_q.vcc_ok & ~pin_d.vcc_ok;

  // Address recovery stack, entry 0 is the current address
  logic [7:0] stk_q [rxc_pkg::STACK_DEPTH];
  logic [7:0] stk_d [rxc_pkg::STACK_DEPTH];
  assign stk_d[0] = ale_fall ? pin_q.ad : stk_q[0];
  for (genvar i = 1; i < rxc_pkg::STACK_DEPTH; i++) begin : g_stk
    assign stk_d[i] = ale_fall ? stk_q[i-1] : stk_q[i];
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < rxc_pkg::STACK_DEPTH; k++) begin
        stk_q[k] <= 8'h00;
      end
    end else begin
      for (int k = 0; k < rxc_pkg::STACK_DEPTH; k++) begin
        stk_q[k] <= stk_d[k];
      end
    end
  end

  // Access decode; bank 1 selection is software's job beforehand
  logic sel, wr_a, wr_b;
  assign sel = BANK_SELECT_I & ~pin_q.cs_n;
  assign wr_a = sel & wr_rise & (stk_q[0] == rxc_pkg::ADDR_CTL_A);
  assign wr_b = sel & wr_rise & (stk_q[0] == rxc_pkg::ADDR_CTL_B);

  // Update status sequencer
  rxc_pkg::rxc_upd_type upd_q, upd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic go_d;

  always_comb begin
    upd_d = upd_q;
    cnt_d = cnt_q;
    go_d = 1'b0;
    case (upd_q)
      rxc_pkg::UPD_IDLE: begin
        if (UPDATE_REQ_I) begin
          upd_d = rxc_pkg::UPD_LEAD;
          cnt_d = '0;
        end
      end
      rxc_pkg::UPD_LEAD: begin
        if (cnt_q == LEAD_LAST) begin
          upd_d = rxc_pkg::UPD_BUSY;
          go_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      rxc_pkg::UPD_BUSY: begin
        if (UPDATE_DONE_I) begin
          upd_d = rxc_pkg::UPD_IDLE;
        end
      end
      default: begin
        upd_d = rxc_pkg::UPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      upd_q <= rxc_pkg::UPD_IDLE;
      cnt_q <= '0;
    end else begin
      upd_q <= upd_d;
      cnt_q <= cnt_d;
    end
  end

  // Control registers
  rxc_pkg::rxc_ctl_a_type ca_q, ca_d;
  rxc_pkg::rxc_ctl_b_type cb_q, cb_d;
  rxc_pkg::rxc_ctl_a_type wa;

  always_comb begin
    wa = pin_q.ad;
    ca_d = ca_q;
    cb_d = cb_q;
    if (wr_b) begin
      cb_d = pin_q.ad;
    end
    // Power-up forces the oscillator output on over a write
    if (vcc_rise) begin
      cb_d.osc_en = 1'b1;
    end
    if (wr_a) begin
      ca_d.burst = wa.burst;
      ca_d.resv = wa.resv;
      ca_d.power_off_ctl = wa.power_off_ctl;
      ca_d.rf = wa.rf;
      ca_d.wf = wa.wf;
      ca_d.kf = wa.kf;
    end
    // Hardware sets win over a clearing write in the same cycle
    if (ram_clear_in_fall && cb_q.ram_clear_en) begin
      ca_d.rf = 1'b1;
    end
    if (WAKE_EVENT_I) begin
      ca_d.wf = 1'b1;
    end
    if (kick_fall && cb_q.kick_en) begin
      ca_d.kf = 1'b1;
    end
    if (vcc_fall && !cb_q.power_fail_keep) begin
      ca_d.power_off_ctl = 1'b1;
    end
    if ((ca_d.wf && cb_d.wake_int_en) || (ca_d.kf && cb_d.kick_en)) begin
      ca_d.power_off_ctl = 1'b0;
    end
    ca_d.batt_ok = pin_q.batt_ok;
    ca_d.upd = (upd_d != rxc_pkg::UPD_IDLE);
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ca_q <= rxc_pkg::CTL_A_RST;
      cb_q <= rxc_pkg::CTL_B_RST;
    end else begin
      ca_q <= ca_d;
      cb_q <= cb_d;
    end
  end

  // Registered outputs and read port
  logic irq_d, rd_en, hit;
  logic [7:0] rdata;

  always_comb begin
    // Interrupt only while main power is present
    irq_d = pin_q.vcc_ok &&
            ((ca_q.wf && cb_q.wake_int_en) || (ca_q.kf && cb_q.kick_en) ||
             (ca_q.rf && cb_q.ram_clear_int_en));
    hit = 1'b1;
    case (stk_q[0])
      rxc_pkg::ADDR_CTL_A: rdata = ca_q;
      rxc_pkg::ADDR_CTL_B: rdata = cb_q;
      rxc_pkg::ADDR_STK_LO: rdata = stk_q[rxc_pkg::STK_IDX_LO];
      rxc_pkg::ADDR_STK_HI: rdata = stk_q[rxc_pkg::STK_IDX_HI];
      default: begin
        rdata = 8'h00;
        hit = 1'b0;
      end
    endcase
    rd_en = sel & ~pin_q.rd_n & hit;
  end

  logic pwr_oe_q, irq_oe_q, go_q, inc_q, clr_q, ad_oe_q;
  logic [7:0] ad_q;
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pwr_oe_q <= 1'b0;
      irq_oe_q <= 1'b0;
      go_q <= 1'b0;
      inc_q <= 1'b0;
      clr_q <= 1'b0;
      ad_oe_q <= 1'b0;
      ad_q <= 8'h00;
    end else begin
      pwr_oe_q <= ~ca_d.power_off_ctl;
      irq_oe_q <= irq_d;
      go_q <= go_d;
      inc_q <= sel & (rd_rise | wr_rise) & ca_q.burst &
               (stk_q[0] == rxc_pkg::ADDR_BURST_DATA);
      clr_q <= ram_clear_in_fall & cb_q.ram_clear_en;
      ad_oe_q <= rd_en;
      ad_q <= rdata;
    end
  end

  assign PWR_N_O = 1'b0;
  assign IRQ_N_O = 1'b0;
  assign PWR_OE_O = pwr_oe_q;
  assign IRQ_OE_O = irq_oe_q;
  assign UPDATE_GO_O = go_q;
  assign BURST_INC_O = inc_q;
  assign RAM_CLEAR_O = clr_q;
  assign AD_OE_O = ad_oe_q;
  assign AD_O = ad_q;
  assign SQW_EN_O = cb_q.osc_en;
  assign XTAL_LOAD_SEL_O = cb_q.xtal;
  assign AUX_SUPPLY_EN_O = cb_q.aux_en;

  // Checks
  default clocking cb_chk @(posedge CLK_I);
  endclocking
  default disable iff (!rst_n);

  pab_clear_a: assert property (
    (ca_q.wf && cb_q.wake_int_en) || (ca_q.kf && cb_q.kick_en) |-> !ca_q.power_off_ctl
  ) else $error("power_off_ctl set while enabled flag pending");

  pwr_follow_a: assert property (
    PWR_OE_O == !ca_q.power_off_ctl
  ) else $error("power output does not follow power_off_ctl");

  irq_drive_a: assert property (
    pin_q.vcc_ok && ca_q.wf && cb_q.wake_int_en |=> IRQ_OE_O
  ) else $error("enabled wake flag did not drive interrupt");

  irq_unpow_a: assert property (
    !pin_q.vcc_ok |=> !IRQ_OE_O
  ) else $error("interrupt driven without main power");

  ram_clear_in_set_a: assert property (
    ram_clear_in_fall && cb_q.ram_clear_en |=> ca_q.rf && RAM_CLEAR_O
  ) else $error("RAM clear edge did not set flag");

  ram_clear_in_off_a: assert property (
    ram_clear_in_fall && !cb_q.ram_clear_en && !wr_a |=> $stable(ca_q.rf) && !RAM_CLEAR_O
  ) else $error("RAM clear acted while disabled");

  kick_set_a: assert property (
    kick_fall && cb_q.kick_en |=> ca_q.kf ##1 !ca_q.power_off_ctl
  ) else $error("kick did not set flag and enable power");

  stk_push_a: assert property (
    ale_fall |=> stk_q[1] == $past(stk_q[0]) && stk_q[3] == $past(stk_q[2])
  ) else $error("address stack did not push");

  stk_read_a: assert property (
    rd_en && stk_q[0] == rxc_pkg::ADDR_STK_LO
    |=> AD_OE_O && AD_O == $past(stk_q[2])
  ) else $error("stack low read wrong");

  upd_lead_a: assert property (
    upd_q == rxc_pkg::UPD_LEAD && cnt_q == LEAD_LAST |=> ca_q.upd && UPDATE_GO_O
  ) else $error("update start not preceded by busy");

  osc_pwrup_a: assert property (
    vcc_rise |=> SQW_EN_O
  ) else $error("oscillator output not enabled at power-up");

  pfail_a: assert property (
    vcc_fall && !cb_q.power_fail_keep && !ca_d.wf && !ca_d.kf ##1 !wr_a |=> !PWR_OE_O
  ) else $error("power output stayed active on power fail");

  burst_a: assert property (
    sel && rd_rise && ca_q.burst && stk_q[0] == rxc_pkg::ADDR_BURST_DATA
    |=> BURST_INC_O
  ) else $error("burst increment missing");

  wake_cov: cover property (WAKE_EVENT_I && cb_q.wake_int_en ##[1:4] PWR_OE_O);
  upd_cov: cover property (UPDATE_GO_O ##[1:20] upd_q == rxc_pkg::UPD_IDLE);
  stk_cov: cover property (rd_en && stk_q[0] == rxc_pkg::ADDR_STK_HI);
  ram_clear_in_cov: cover property (RAM_CLEAR_O ##1 IRQ_OE_O);

endmodule

// ### verification/rxc_host_model.sv
`timescale 1ns/1ns
module rxc_host_model (
  // Clock
  input wire logic clk_i,
  // Bus towards the device
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic cs_n_o,
  output logic bank_o,
  output logic [7:0] ad_o,
  // Device pins
  output logic kick_n_o,
  output logic ram_clear_in_n_o,
  // Device read drive
  input wire logic [7:0] dev_ad_i,
  input wire logic dev_oe_i
);
  logic drv;
  logic [7:0] val;
  // Released bus shows the inverse of the last value, never a stale copy
  assign ad_o = dev_oe_i ? dev_ad_i : (drv ? val : ~val);
  initial begin
    ale_o = 1'b0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    cs_n_o = 1'b1;
    bank_o = 1'b0;
    kick_n_o = 1'b1;
    ram_clear_in_n_o = 1'b1;
    drv = 1'b0;
    val = 8'h00;
  end
  // Low pulse on the kickstart or RAM clear pin, long enough for the filter
  task automatic pin_pulse(input logic ram_clear_in);
    @(negedge clk_i);
    if (ram_clear_in) begin
      ram_clear_in_n_o = 1'b0;
    end else begin
      kick_n_o = 1'b0;
    end
    repeat (8) @(negedge clk_i);
    ram_clear_in_n_o = 1'b1;
    kick_n_o = 1'b1;
    repeat (10) @(negedge clk_i);
  endtask
  task automatic bank(input logic b);
    @(negedge clk_i);
    bank_o = b;
  endtask
  // Address stays driven; the caller decides what follows
  task automatic latch(input logic [7:0] a);
    @(negedge clk_i);
    val = a;
    drv = 1'b1;
    ale_o = 1'b1;
    repeat (8) @(negedge clk_i);
    ale_o = 1'b0;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    latch(a);
    val = d;
    cs_n_o = 1'b0;
    wr_n_o = 1'b0;
    repeat (8) @(negedge clk_i);
    wr_n_o = 1'b1;
    repeat (8) @(negedge clk_i);
    cs_n_o = 1'b1;
    drv = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    latch(a);
    drv = 1'b0;
    cs_n_o = 1'b0;
    rd_n_o = 1'b0;
    ok = 1'b0;
    d = 8'hXX;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge clk_i);
      if (dev_oe_i === 1'b1) begin
        ok = 1'b1;
        d = dev_ad_i;
      end
    end
    @(negedge clk_i);
    rd_n_o = 1'b1;
    cs_n_o = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam int UPD_LEAD = 8;
  logic clk, rst_n, ale, rd_n, wr_n, cs_n, bank, ad_oe, ok;
  logic kick_n, ram_clear_in_n, vcc, batt, wake, upd_req, upd_done;
  logic go, binc, ram_clear_in, pwr_n, pwr_oe, irq_n, irq_oe, square_wave_out, xtal, aux;
  logic [7:0] ad, ad_dev, d, bursts, clears;
  int bad_count, checks, cyc, n;
  // Open-drain pins with pull-ups
  wire pwr_pin = pwr_oe ? pwr_n : 1'b1;
  wire irq_pin = irq_oe ? irq_n : 1'b1;
  rxc_ext_ctl #(.UPDATE_LEAD_CYC(UPD_LEAD)) rxc_ext_ctl_i (
    .CLK_I(clk), .RST_N_I(rst_n), .ALE_I(ale), .RD_N_I(rd_n),
    .WR_N_I(wr_n), .CS_N_I(cs_n), .AD_I(ad), .AD_O(ad_dev),
    .AD_OE_O(ad_oe), .BANK_SELECT_I(bank), .KICKSTART_N_I(kick_n),
    .RAM_CLEAR_N_I(ram_clear_in_n), .VCC_OK_I(vcc), .AUX_BATTERY_OK_I(batt),
    .WAKE_EVENT_I(wake), .UPDATE_REQ_I(upd_req),
    .UPDATE_DONE_I(upd_done), .UPDATE_GO_O(go), .BURST_INC_O(binc),
    .RAM_CLEAR_O(ram_clear_in), .PWR_N_O(pwr_n), .PWR_OE_O(pwr_oe),
    .IRQ_N_O(irq_n), .IRQ_OE_O(irq_oe), .SQW_EN_O(square_wave_out),
    .XTAL_LOAD_SEL_O(xtal), .AUX_SUPPLY_EN_O(aux));
  rxc_host_model rxc_host_model_i (
    .clk_i(clk), .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .cs_n_o(cs_n), .bank_o(bank), .ad_o(ad), .kick_n_o(kick_n),
    .ram_clear_in_n_o(ram_clear_in_n), .dev_ad_i(ad_dev),
    .dev_oe_i(ad_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    bursts <= bursts + {7'h00, binc === 1'b1};
    clears <= clears + {7'h00, ram_clear_in === 1'b1};
    cyc <= cyc + 1;
    // Hang guard, well above the expected run length
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    rxc_host_model_i.rd(a, d, ok);
    chk(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    rxc_host_model_i.wr(a, v);
  endtask
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic t_reset();
    rxc_host_model_i.bank(1'b1);
    rdc(8'h4A, rxc_pkg::CTL_A_RST);
    rdc(8'h4B, rxc_pkg::CTL_B_RST);
    chk({6'h00, pwr_pin, square_wave_out}, 8'h03);
  endtask
  task automatic t_regs();
    wr(8'h4B, 8'hA5);
    rdc(8'h4B, 8'hA5);
    chk({5'h00, aux, square_wave_out, xtal}, 8'h05);
    rxc_host_model_i.bank(1'b0);
    wr(8'h4B, 8'h00);
    rxc_host_model_i.bank(1'b1);
    rdc(8'h4B, 8'hA5);
    rxc_host_model_i.rd(8'h4C, d, ok);
    chk({7'h00, ok}, 8'h00);
    wr(8'h4A, 8'hD0);
    rdc(8'h4A, 8'h10);
    chk({7'h00, pwr_pin}, 8'h00);
    wr(8'h4A, 8'h08);
    chk({7'h00, pwr_pin}, 8'h01);
    batt = 1'b1;
    vcc = 1'b1;
    tick(10);
    rdc(8'h4A, 8'h88);
    rdc(8'h4B, 8'hE5);
  endtask
  task automatic t_update();
    upd_req = 1'b1;
    tick(1);
    upd_req = 1'b0;
    n = 0;
    while (go !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(8'(n), 8'(UPD_LEAD));
    rdc(8'h4A, 8'hC8);
    upd_done = 1'b1;
    tick(1);
    upd_done = 1'b0;
    rdc(8'h4A, 8'h88);
  endtask
  task automatic t_events();
    wake = 1'b1;
    tick(1);
    wake = 1'b0;
    tick(3);
    chk({6'h00, pwr_pin, irq_pin}, 8'h03);
    rdc(8'h4A, 8'h8A);
    wr(8'h4A, 8'h08);
    wr(8'h4B, 8'hE7);
    wake = 1'b1;
    tick(1);
    wake = 1'b0;
    tick(3);
    chk({6'h00, pwr_pin, irq_pin}, 8'h00);
    rdc(8'h4A, 8'h82);
    // Flags are cleared before power_off_ctl is set again
    wr(8'h4A, 8'h00);
    wr(8'h4A, 8'h08);
    chk({6'h00, pwr_pin, irq_pin}, 8'h03);
    rxc_host_model_i.pin_pulse(1'b0);
    chk({6'h00, pwr_pin, irq_pin}, 8'h00);
    rdc(8'h4A, 8'h81);
    wr(8'h4A, 8'h00);
    vcc = 1'b0;
    tick(10);
    chk({7'h00, pwr_pin}, 8'h01);
    wake = 1'b1;
    tick(1);
    wake = 1'b0;
    tick(3);
    chk({6'h00, pwr_pin, irq_pin}, 8'h01);
    vcc = 1'b1;
    tick(10);
    chk({6'h00, pwr_pin, irq_pin}, 8'h00);
    wr(8'h4A, 8'h00);
    wr(8'h4A, 8'h08);
    // power_fail_keep set: power output stays driven through a power fail
    wr(8'h4B, 8'hEF);
    wr(8'h4A, 8'h00);
    vcc = 1'b0;
    tick(10);
    chk({7'h00, pwr_pin}, 8'h00);
    vcc = 1'b1;
    tick(10);
    wr(8'h4A, 8'h08);
  endtask
  task automatic t_ram_clear_in();
    rxc_host_model_i.pin_pulse(1'b1);
    chk(clears, 8'h00);
    rdc(8'h4A, 8'h88);
    wr(8'h4B, 8'hF7);
    rxc_host_model_i.pin_pulse(1'b1);
    chk(clears, 8'h01);
    chk({7'h00, irq_pin}, 8'h00);
    rdc(8'h4A, 8'h8C);
    wr(8'h4A, 8'h08);
    chk({7'h00, irq_pin}, 8'h01);
    wr(8'h4A, 8'h0C);
    rdc(8'h4A, 8'h8C);
    wr(8'h4A, 8'h08);
  endtask
  task automatic t_burst();
    wr(8'h53, 8'h5A);
    chk(bursts, 8'h00);
    wr(8'h4A, 8'h28);
    wr(8'h53, 8'hA5);
    chk(bursts, 8'h01);
    rxc_host_model_i.rd(8'h53, d, ok);
    chk(bursts, 8'h02);
    wr(8'h52, 8'h00);
    chk(bursts, 8'h02);
    wr(8'h4A, 8'h08);
  endtask
  task automatic t_stack();
    rxc_host_model_i.latch(8'h11);
    rxc_host_model_i.latch(8'h22);
    rxc_host_model_i.latch(8'h33);
    rdc(8'h4F, 8'h11);
    rxc_host_model_i.latch(8'h0A);
    rdc(8'h4E, 8'h4F);
  endtask
  initial begin
    {rst_n, vcc, batt} = 3'b000;
    {wake, upd_req, upd_done, bursts, clears} = 19'h0;
    {bad_count, checks, cyc} = '0;
    tick(10);
    rst_n = 1'b1;
    tick(12);
    t_reset();
    t_regs();
    t_update();
    t_events();
    t_ram_clear_in();
    t_burst();
    t_stack();
    end_of_test();
  end
endmodule
